//--- logic/pcr_pkg.sv
// Shared constants and types for the clock driver and its partner.
package pcr_pkg;
    localparam int unsigned CLK_PERIOD_PS         = 4000;
    localparam int unsigned MIN_REQ_PULSE_NS      = 10;
    localparam int unsigned MIN_REQ_PULSE_PS      = MIN_REQ_PULSE_NS * 1000;
    localparam int unsigned MIN_REQ_PULSE_CYCLES  = (MIN_REQ_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned RESET_HOLD_CYCLES     = 1024;
    localparam int unsigned REF_CYCLES_PER_HOLD   = 512;
    localparam int unsigned HOLD_COUNT_W          = 10;
    localparam int unsigned PHASE_W               = 3;
    localparam int unsigned IN_PHASE_BIT          = 1;
    localparam int unsigned FEEDBACK_BIT          = 2;
    localparam int unsigned NUM_IN_PHASE          = 3;
    localparam int unsigned REQ_COUNT_W           = 3;
    localparam int unsigned REF_HALF_PERIOD       = 4;
    localparam int unsigned REF_COUNT_W           = 3;
    localparam logic [PHASE_W-1:0]      PHASE_ALIGN  = 3'h1;
    localparam logic [HOLD_COUNT_W-1:0] HOLD_LAST    = 10'h3ff;
    localparam logic [REQ_COUNT_W-1:0]  REQ_TAKEN_AT = 3'(MIN_REQ_PULSE_CYCLES - 1);
    localparam logic [REF_COUNT_W-1:0]  REF_HALF_LAST = 3'(REF_HALF_PERIOD - 1);

    typedef enum logic [1:0] {
        ST_POWERUP,
        ST_HELD,
        ST_COUNT,
        ST_RUN
    } pcr_state_t;
endpackage

//--- logic/pcr_link_if.sv
// Pins between the clock driver and the processor with its board logic.
`timescale 1ns/1ps
interface pcr_link_if;
    logic [pcr_pkg::NUM_IN_PHASE-1:0] in_phase_clock_outs;
    logic                             inverted_clock_out;
    logic                             double_rate_clock_out;
    logic                             half_rate_enable_out;
    logic                             resetLockOut;
    logic                             resetLockEnableN;
    logic                             resetLockLine;
    logic                             refClock;
    logic                             loopEnable;
    logic                             resetRequestN;

    // The pull-up raises the open-drain line whenever nobody pulls it low.
    assign resetLockLine = resetLockEnableN ? 1'b1 : resetLockOut;

    modport device_end (
        output in_phase_clock_outs,
        output inverted_clock_out,
        output double_rate_clock_out,
        output half_rate_enable_out,
        output resetLockOut,
        output resetLockEnableN,
        input  refClock,
        input  loopEnable,
        input  resetRequestN
    );

    modport host_end (
        input  in_phase_clock_outs,
        input  inverted_clock_out,
        input  double_rate_clock_out,
        input  half_rate_enable_out,
        input  resetLockLine,
        output refClock,
        output loopEnable,
        output resetRequestN
    );
endinterface

//--- logic/pcr_device_end.sv
// Clock multiplier, distributor and processor reset sequencer.
`timescale 1ns/1ps
module pcr_device_end (
    input  wire logic clk,
    input  wire logic reset,
    pcr_link_if.device_end link,
    input  wire logic loopLocked,
    output      logic resetHeld,
    output      logic lockSeen
);
    logic                              refPrev;
    logic                              next_refPrev;
    logic [pcr_pkg::PHASE_W-1:0]       phase;
    logic [pcr_pkg::PHASE_W-1:0]       next_phase;
    logic                              refRise;

    logic [pcr_pkg::NUM_IN_PHASE-1:0]  inPhase;
    logic [pcr_pkg::NUM_IN_PHASE-1:0]  next_inPhase;
    logic                              inverted;
    logic                              next_inverted;
    logic                              doubleRate;
    logic                              next_doubleRate;
    logic                              halfEnable;
    logic                              next_halfEnable;
    logic                              inPhasePrev;
    logic                              next_inPhasePrev;
    logic                              inPhaseTick;

    logic [pcr_pkg::REQ_COUNT_W-1:0]   lowCount;
    logic [pcr_pkg::REQ_COUNT_W-1:0]   next_lowCount;
    logic                              reqTaken;

    pcr_pkg::pcr_state_t               state;
    pcr_pkg::pcr_state_t               next_state;
    logic [pcr_pkg::HOLD_COUNT_W-1:0]  holdCount;
    logic [pcr_pkg::HOLD_COUNT_W-1:0]  next_holdCount;
    logic                              releaseN;
    logic                              next_releaseN;
    logic                              heldFlag;
    logic                              next_heldFlag;
    logic                              lockFlag;
    logic                              next_lockFlag;

    // Reference edge detection and the phase counter standing in for the loop.
    assign refRise = link.refClock && !refPrev;

    always_comb begin
        next_refPrev = link.refClock;
        if (refRise && link.loopEnable) begin
            // Aligning the counter to the reference edge closes the loop at Q/2.
            next_phase = pcr_pkg::PHASE_ALIGN;
        end else begin
            next_phase = phase + 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            refPrev <= 1'b0;
            phase   <= '0;
        end else begin
            refPrev <= next_refPrev;
            phase   <= next_phase;
        end
    end

    // Clock outputs, generated from the phase counter or passed through in test mode.
    always_comb begin
        next_inPhasePrev = inPhase[0];
        if (link.loopEnable) begin
            next_doubleRate = phase[0];
            next_halfEnable = phase[0] ^ phase[pcr_pkg::IN_PHASE_BIT];
            next_inverted   = !phase[pcr_pkg::IN_PHASE_BIT];
        end else begin
            next_doubleRate = link.refClock;
            next_halfEnable = link.refClock;
            next_inverted   = !link.refClock;
        end
    end

    generate
        for (genvar i = 0; i < pcr_pkg::NUM_IN_PHASE; i++) begin : gInPhase
            always_comb begin
                if (link.loopEnable) begin
                    next_inPhase[i] = phase[pcr_pkg::IN_PHASE_BIT];
                end else begin
                    next_inPhase[i] = link.refClock;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (reset) begin
            inPhase     <= '0;
            inverted    <= 1'b1;
            doubleRate  <= 1'b0;
            halfEnable  <= 1'b0;
            inPhasePrev <= 1'b0;
        end else begin
            inPhase     <= next_inPhase;
            inverted    <= next_inverted;
            doubleRate  <= next_doubleRate;
            halfEnable  <= next_halfEnable;
            inPhasePrev <= next_inPhasePrev;
        end
    end

    // One tick for each rising edge of the in-phase output clock.
    assign inPhaseTick = inPhase[0] && !inPhasePrev;

    // A request counts only once it has stayed low for the minimum pulse width.
    assign reqTaken = !link.resetRequestN && (lowCount == pcr_pkg::REQ_TAKEN_AT);

    always_comb begin
        if (link.resetRequestN) begin
            next_lowCount = '0;
        end else if (lowCount == pcr_pkg::REQ_TAKEN_AT) begin
            next_lowCount = lowCount;
        end else begin
            next_lowCount = lowCount + 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            lowCount <= '0;
        end else begin
            lowCount <= next_lowCount;
        end
    end

    // Reset sequencer; it never touches the clock generation above.
    always_comb begin
        next_state     = state;
        next_holdCount = holdCount;
        next_lockFlag  = lockFlag || loopLocked;
        case (state)
            pcr_pkg::ST_POWERUP: begin
                // Low request or missing lock both keep the processor in reset.
                if (link.resetRequestN && loopLocked) begin
                    next_state     = pcr_pkg::ST_COUNT;
                    next_holdCount = '0;
                end
            end
            pcr_pkg::ST_HELD: begin
                if (link.resetRequestN) begin
                    next_state     = pcr_pkg::ST_COUNT;
                    next_holdCount = '0;
                end
            end
            pcr_pkg::ST_COUNT: begin
                if (reqTaken) begin
                    next_state = pcr_pkg::ST_HELD;
                end else if (inPhaseTick) begin
                    if (holdCount == pcr_pkg::HOLD_LAST) begin
                        next_state = pcr_pkg::ST_RUN;
                    end else begin
                        next_holdCount = holdCount + 10'h001;
                    end
                end
            end
            pcr_pkg::ST_RUN: begin
                if (reqTaken) begin
                    next_state = pcr_pkg::ST_HELD;
                end
            end
            default: begin
                next_state = pcr_pkg::ST_POWERUP;
            end
        endcase
        // Released line is left floating for the pull-up; it is never driven high.
        next_releaseN = (next_state == pcr_pkg::ST_RUN);
        next_heldFlag = (next_state != pcr_pkg::ST_RUN);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state     <= pcr_pkg::ST_POWERUP;
            holdCount <= '0;
            releaseN  <= 1'b0;
            heldFlag  <= 1'b1;
            lockFlag  <= 1'b0;
        end else begin
            state     <= next_state;
            holdCount <= next_holdCount;
            releaseN  <= next_releaseN;
            heldFlag  <= next_heldFlag;
            lockFlag  <= next_lockFlag;
        end
    end

    // Clock outputs stay live in every sequencer state.
    assign link.in_phase_clock_outs   = inPhase;
    assign link.inverted_clock_out    = inverted;
    assign link.double_rate_clock_out = doubleRate;
    assign link.half_rate_enable_out  = halfEnable;
    assign link.resetLockOut          = 1'b0;
    assign link.resetLockEnableN      = releaseN;
    assign resetHeld                  = heldFlag;
    assign lockSeen                   = lockFlag;
endmodule // pcr_device_end

//--- logic/pcr_host_end.sv
// Board reset logic and processor clock input side of the link.
`timescale 1ns/1ps
module pcr_host_end (
    input  wire logic clk,
    input  wire logic reset,
    pcr_link_if.host_end link,
    input  wire logic testMode,
    input  wire logic startupDone,
    input  wire logic resetPulse,
    output      logic processorInReset,
    output      logic processor_clock_enable
);
    logic [pcr_pkg::REF_COUNT_W-1:0] refCount;
    logic [pcr_pkg::REF_COUNT_W-1:0] next_refCount;
    logic                            refLevel;
    logic                            next_refLevel;
    logic [pcr_pkg::REQ_COUNT_W-1:0] pulseCount;
    logic [pcr_pkg::REQ_COUNT_W-1:0] next_pulseCount;
    logic                            requestN;
    logic                            next_requestN;
    logic                            loopEn;
    logic                            next_loopEn;
    logic                            inReset;
    logic                            next_inReset;
    logic                            clkEnable;
    logic                            next_clkEnable;

    always_comb begin
        // Reference divider keeps the input inside the locked frequency range.
        if (refCount == pcr_pkg::REF_HALF_LAST) begin
            next_refCount = '0;
            next_refLevel = !refLevel;
        end else begin
            next_refCount = refCount + 3'h1;
            next_refLevel = refLevel;
        end
        next_loopEn = !testMode;
        if (resetPulse) begin
            next_pulseCount = pcr_pkg::REQ_TAKEN_AT;
        end else if (pulseCount != '0) begin
            next_pulseCount = pulseCount - 3'h1;
        end else begin
            next_pulseCount = pulseCount;
        end
        // Request stays low through start-up and for the whole pulse.
        next_requestN  = startupDone && !resetPulse && (pulseCount == '0);
        next_inReset   = !link.resetLockLine;
        next_clkEnable = link.half_rate_enable_out;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            refCount   <= '0;
            refLevel   <= 1'b0;
            pulseCount <= '0;
            requestN   <= 1'b0;
            loopEn     <= 1'b1;
            inReset    <= 1'b1;
            clkEnable  <= 1'b0;
        end else begin
            refCount   <= next_refCount;
            refLevel   <= next_refLevel;
            pulseCount <= next_pulseCount;
            requestN   <= next_requestN;
            loopEn     <= next_loopEn;
            inReset    <= next_inReset;
            clkEnable  <= next_clkEnable;
        end
    end

    assign link.refClock          = refLevel;
    assign link.loopEnable        = loopEn;
    assign link.resetRequestN     = requestN;
    assign processorInReset       = inReset;
    assign processor_clock_enable = clkEnable;
endmodule // pcr_host_end

//--- tb/pcr_link_properties.sv
// Concurrent checks on the link between the clock driver and its processor side.
`timescale 1ns/1ps
module pcr_link_properties (
    input wire logic                             clk,
    input wire logic                             reset,
    input wire logic [pcr_pkg::NUM_IN_PHASE-1:0] in_phase_clock_outs,
    input wire logic                             inverted_clock_out,
    input wire logic                             double_rate_clock_out,
    input wire logic                             half_rate_enable_out,
    input wire logic                             resetLockOut,
    input wire logic                             resetLockEnableN,
    input wire logic                             refClock,
    input wire logic                             loopEnable,
    input wire logic                             resetRequestN
);
    logic [4:0]  warmCnt;
    logic [4:0]  next_warmCnt;
    logic [12:0] highCnt;
    logic [12:0] next_highCnt;
    logic        warm;

    // Counts cycles with the loop enabled and cycles with the request released.
    always_comb begin
        next_warmCnt = loopEnable ? warmCnt + 5'(warmCnt != 5'h1f) : 5'h0;
        next_highCnt = resetRequestN ? highCnt + 13'(highCnt != 13'h1fff) : 13'h0;
    end

    always_ff @(posedge clk) begin
        warmCnt <= reset ? 5'h0 : next_warmCnt;
        highCnt <= reset ? 13'h0 : next_highCnt;
    end

    assign warm = (warmCnt == 5'h1f);

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    a_inverse_clock: assert property (inverted_clock_out == !in_phase_clock_outs[0])
        else $error("inverted clock is not the inverse");
    a_in_phase_equal: assert property ((&in_phase_clock_outs) || !(|in_phase_clock_outs))
        else $error("in-phase clocks differ");
    a_double_toggle: assert property (warm |-> double_rate_clock_out != $past(double_rate_clock_out))
        else $error("double-rate clock missed a toggle");
    a_in_phase_period: assert property (warm && $rose(in_phase_clock_outs[0]) |=>
        $stable(in_phase_clock_outs[0]) ##1 !in_phase_clock_outs[0]) else $error("in-phase high time wrong");
    a_enable_skew: assert property (warm |->
        half_rate_enable_out == (double_rate_clock_out ^ in_phase_clock_outs[0])) else $error("enable phase wrong");
    a_test_follow: assert property (!loopEnable && !$past(loopEnable) |->
        in_phase_clock_outs[0] == $past(refClock)) else $error("test mode output not following reference");
    a_drain_never_high: assert property (resetLockOut == 1'b0)
        else $error("reset line data driven high");
    a_request_taken: assert property (!resetRequestN [*3] |=> !resetLockEnableN)
        else $error("reset request not taken");
    a_release_late: assert property ($rose(resetLockEnableN) |-> highCnt >= 13'hffa)
        else $error("reset line released early");
    a_release_bound: assert property (highCnt == 13'h1130 |-> resetLockEnableN)
        else $error("reset line not released");

    c_release: cover property ($rose(resetLockEnableN));
    c_hold: cover property ($fell(resetLockEnableN));
    c_test: cover property (!loopEnable && warmCnt == 5'h0);
endmodule // pcr_link_properties

//--- tb/pll_clock_reset_driver_tb.sv
// Self-checking bench for the clock driver joined to its processor side.
`timescale 1ns/1ps
module pll_clock_reset_driver_tb;
    logic clk;
    logic reset;
    logic loopLocked;
    logic testMode;
    logic startupDone;
    logic resetPulse;
    logic resetHeld;
    logic lockSeen;
    logic processorInReset;
    logic processor_clock_enable;
    int   n_fail;
    int   checks_done;
    int   cyc;

    pcr_link_if link ();
    pcr_device_end pcr_device_end_inst (.clk(clk), .reset(reset), .link(link), .loopLocked(loopLocked),
        .resetHeld(resetHeld), .lockSeen(lockSeen));
    pcr_host_end pcr_host_end_inst (.clk(clk), .reset(reset), .link(link), .testMode(testMode),
        .startupDone(startupDone), .resetPulse(resetPulse), .processorInReset(processorInReset),
        .processor_clock_enable(processor_clock_enable));
    pcr_link_properties pcr_link_properties_inst (.clk(clk), .reset(reset),
        .in_phase_clock_outs(link.in_phase_clock_outs), .inverted_clock_out(link.inverted_clock_out),
        .double_rate_clock_out(link.double_rate_clock_out), .half_rate_enable_out(link.half_rate_enable_out),
        .resetLockOut(link.resetLockOut), .resetLockEnableN(link.resetLockEnableN), .refClock(link.refClock),
        .loopEnable(link.loopEnable), .resetRequestN(link.resetRequestN));

    initial clk = 1'b0;
    always #2 clk = ~clk;

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_cnt(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        checks_done++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask

    task automatic step();
        @(posedge clk);
        #1;
    endtask

    task automatic do_reset();
        reset = 1'b1;
        repeat (2) step();
        reset = 1'b0;
    endtask

    task automatic pulse_request();
        resetPulse = 1'b1;
        step();
        resetPulse = 1'b0;
    endtask

    // Waits a bounded time for the reset line to reach a level.
    task automatic wait_line(input logic level, input int bound);
        cyc = 0;
        while (link.resetLockLine !== level && cyc < bound) begin
            step();
            cyc++;
        end
        if (link.resetLockLine !== level) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, link.resetLockLine, level);
            end_sim();
        end
    endtask

    function automatic logic pick(input int sel);
        case (sel)
            0: return link.double_rate_clock_out;
            1: return link.in_phase_clock_outs[0];
            2: return link.in_phase_clock_outs[2];
            default: return processor_clock_enable;
        endcase
    endfunction

    task automatic count_rises(input int sel, input int n);
        logic prev;
        cyc = 0;
        repeat (n) begin
            prev = pick(sel);
            step();
            if (prev === 1'b0 && pick(sel) === 1'b1) cyc++;
        end
    endtask

    initial begin
        reset = 1'b1;
        loopLocked = 1'b0;
        testMode = 1'b0;
        startupDone = 1'b0;
        resetPulse = 1'b0;
        n_fail = 0;
        checks_done = 0;
        do_reset();
        loopLocked = 1'b1;
        repeat (200) step();
        check_bit(link.resetLockLine, 1'b0);
        check_bit(processorInReset, 1'b1);
        check_bit(lockSeen, 1'b1);
        count_rises(0, 64); check_cnt(cyc, 32, 32);
        count_rises(1, 64); check_cnt(cyc, 16, 16);
        count_rises(2, 64); check_cnt(cyc, 16, 16);
        count_rises(3, 64); check_cnt(cyc, 16, 16);
        startupDone = 1'b1;
        wait_line(1'b1, 5000); check_cnt(cyc, 4092, 4112);
        step();
        check_bit(resetHeld, 1'b0);
        check_bit(processorInReset, 1'b0);
        $display("test start-up with request low done");
        pulse_request();
        wait_line(1'b0, 8);
        check_bit(resetHeld, 1'b1);
        count_rises(1, 64); check_cnt(cyc, 16, 16);
        repeat (2000) step();
        pulse_request();
        wait_line(1'b1, 5000); check_cnt(cyc, 4094, 4115);
        $display("test reset pulse and restart done");
        loopLocked = 1'b0;
        do_reset();
        repeat (100) step();
        check_bit(link.resetLockLine, 1'b0);
        check_bit(lockSeen, 1'b0);
        loopLocked = 1'b1;
        wait_line(1'b1, 5000); check_cnt(cyc, 4092, 4112);
        $display("test start-up with late lock done");
        testMode = 1'b1;
        repeat (8) step();
        count_rises(1, 64); check_cnt(cyc, 8, 8);
        testMode = 1'b0;
        repeat (100) step();
        count_rises(1, 64); check_cnt(cyc, 16, 16);
        $display("test pass-through mode done");
        end_sim();
    end
endmodule // pll_clock_reset_driver_tb
